// file: logic/vsw_pkg.sv
// shared constants for the video switch serial control link
package vsw_pkg;
   // clock and link rates
   localparam int unsigned SYS_CLK_HZ     = 25_000_000;
   localparam int unsigned TW_MAX_CLK_HZ  = 5_000_000;
   localparam int unsigned I2C_MAX_CLK_HZ = 400_000;
   // quarter-bit tick so that one bit never beats the slowest limit
   localparam int unsigned HOST_TICK_DIV  =
      (SYS_CLK_HZ + 4 * I2C_MAX_CLK_HZ - 1) / (4 * I2C_MAX_CLK_HZ);
   localparam int unsigned TW_MIN_DIV     = SYS_CLK_HZ / TW_MAX_CLK_HZ;

   // synchroniser lanes in the device
   localparam int SY_PDN   = 0;
   localparam int SY_MODE  = 1;
   localparam int SY_CSN   = 2;
   localparam int SY_SCLK  = 3;
   localparam int SY_SDI   = 4;
   localparam int SY_SCL   = 5;
   localparam int SY_SDA   = 6;
   localparam int SY_VID   = 7;
   localparam int SY_RAIL  = 8;
   localparam int SY_STR0  = 9;
   localparam int SY_STR1  = 10;
   localparam int SY_WIDTH = 11;

   // frame layout
   localparam logic [4:0] TW_FRAME_BITS  = 5'h10;
   localparam logic [4:0] TW_LAST_INDEX  = 5'h0f;
   localparam logic [4:0] I2C_LAST_INDEX = 5'h1a;
   localparam logic [3:0] I2C_BYTE_BITS  = 4'h8;
   localparam logic [4:0] I2C_FIXED_ADDR = 5'h04;
   localparam logic [4:0] SEL_REG_ADDR   = 5'h00;
   localparam logic [7:0] SEL_REG_RESET  = 8'h00;
   localparam logic [2:0] SEL_OFF        = 3'h0;
   localparam int OUT2_SEL_LSB = 4;
   localparam int OUT1_SEL_LSB = 0;

   // host registers, word addresses
   localparam logic [1:0] HR_CTRL   = 2'h0;
   localparam logic [1:0] HR_CMD    = 2'h1;
   localparam logic [1:0] HR_STATUS = 2'h2;
   localparam logic [3:0] HR_CTRL_RESET = 4'h0;
   localparam int CTRL_PDN_BIT  = 0;
   localparam int CTRL_MODE_BIT = 1;
   localparam int CTRL_TGT_LSB  = 2;
   localparam int CMD_REG_LSB   = 8;

   typedef enum logic [2:0] {
      I_IDLE = 3'h0, I_ADDR = 3'h1, I_ACKA = 3'h3, I_REG = 3'h2,
      I_ACKR = 3'h6, I_DATA = 3'h7, I_ACKD = 3'h5
   } vsw_i2c_state_type;

   typedef enum logic [1:0] {
      H_IDLE = 2'h0, H_START = 2'h1, H_SHIFT = 2'h3, H_STOP = 2'h2
   } vsw_host_state_type;
endpackage

// file: logic/vsw_link_if.sv
// link between host controller and video switch control port
`timescale 1ns/100ps
interface vsw_link_if;
   logic power_down_n;
   logic i2c_select;
   logic chip_select_n;
   logic serial_clock_in;
   logic serial_data_in;
   logic scl;
   logic sda_dev_o;
   logic sda_dev_oen;
   logic sda_host_o;
   logic sda_host_oen;
   logic sda;

   // open-drain wire with pull-up
   assign sda = ~((~sda_dev_oen & ~sda_dev_o) | (~sda_host_oen & ~sda_host_o));

   modport dev (input power_down_n, i2c_select, chip_select_n, serial_clock_in,
                input serial_data_in, scl, sda, output sda_dev_o, sda_dev_oen);
   modport host (output power_down_n, i2c_select, chip_select_n, serial_clock_in,
                 output serial_data_in, scl, sda_host_o, sda_host_oen, input sda);
endinterface

// file: logic/vsw_dev_ctrl.sv
// device end: 3-wire and i2c write ports feeding the input selector register
// Function
// - code 1-7 routes input 1-7 to output one
// - code zero grounds output one, default
// - output two: same encoding, own field
// - no video and rail above limit: internal oscillator
// - select pin low 3-wire, high i2c
// - frame: chip addr, rw one, reg, data
// - act only when chip address matches straps
// - sample data on serial clock rise, select low
// - latch on sixteenth rising edge
// - host raises select after sixteen clocks
// - host serial clock at most 5MHz
// - power-down low resets all registers
// - i2c fast mode, clock at most 400kHz
// - slave address 00100 plus strap bits
// - acknowledge only matching slave address
// - direction bit one read, zero write
// - host sends register address, upper zeros
// - following bytes are data, msb first
// - acknowledge every received write byte
// - host ends with stop, stable data
// - address counter advances after each data byte
// - selector register layout, resets to zero
// - host writes only address zero
//
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
module vsw_dev_ctrl
   import vsw_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       resetn_i,
   vsw_link_if.dev         link,
   input  wire logic       chip_addr_strap0_i,
   input  wire logic       chip_addr_strap1_i,
   input  wire logic       video_present_i,
   input  wire logic       rail_above_limit_i,
   output logic [2:0]      out1_source_select_o,
   output logic [2:0]      out2_source_select_o,
   output logic            video_out_one_ground_o,
   output logic            video_out_two_ground_o,
   output logic            pump_internal_osc_o,
   output logic [7:0]      sel_reg_o
);

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers
   logic [SY_WIDTH-1:0] sync1_reg;
   logic [SY_WIDTH-1:0] sync2_reg;
   logic [SY_WIDTH-1:0] prev_reg;
   logic [SY_WIDTH-1:0] pins;

   assign pins = {chip_addr_strap1_i, chip_addr_strap0_i, rail_above_limit_i,
                  video_present_i, link.sda, link.scl, link.serial_data_in,
                  link.serial_clock_in, link.chip_select_n, link.i2c_select,
                  link.power_down_n};

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg  <= '0;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   logic       pdn_s;
   logic       csn_s;
   logic       sclk_rise;
   logic       scl_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       sda_s;
   logic       i2c_start;
   logic       i2c_stop;
   logic [1:0] strap_s;
   logic       tw_on;
   logic       i2c_on;

   assign pdn_s     = sync2_reg[SY_PDN];
   assign csn_s     = sync2_reg[SY_CSN];
   assign sclk_rise = sync2_reg[SY_SCLK] & ~prev_reg[SY_SCLK];
   assign scl_s     = sync2_reg[SY_SCL];
   assign scl_rise  = scl_s & ~prev_reg[SY_SCL];
   assign scl_fall  = ~scl_s & prev_reg[SY_SCL];
   assign sda_s     = sync2_reg[SY_SDA];
   assign i2c_start = scl_s & prev_reg[SY_SCL] & prev_reg[SY_SDA] & ~sda_s;
   assign i2c_stop  = scl_s & prev_reg[SY_SCL] & ~prev_reg[SY_SDA] & sda_s;
   assign strap_s   = {sync2_reg[SY_STR1], sync2_reg[SY_STR0]};
   assign tw_on     = pdn_s & ~sync2_reg[SY_MODE];
   assign i2c_on    = pdn_s & sync2_reg[SY_MODE];

   ////////////////////////////////////////////////////////////////////////////
   // 3-wire write port
   logic [4:0]  tw_cnt_reg;
   logic [14:0] tw_shift_reg;
   logic [15:0] tw_word;
   logic        tw_wr;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tw_cnt_reg <= '0;
      end else if (csn_s || !tw_on) begin
         tw_cnt_reg <= '0;
      end else if (sclk_rise && tw_cnt_reg != TW_FRAME_BITS) begin
         tw_cnt_reg <= tw_cnt_reg + 5'h01;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tw_shift_reg <= '0;
      end else if (tw_on && !csn_s && sclk_rise && tw_cnt_reg != TW_FRAME_BITS) begin
         tw_shift_reg <= {tw_shift_reg[13:0], sync2_reg[SY_SDI]};
      end
   end

   assign tw_word = {tw_shift_reg, sync2_reg[SY_SDI]};
   // bits above the data: chip address, rw, register address
   assign tw_wr = tw_on && !csn_s && sclk_rise && tw_cnt_reg == TW_LAST_INDEX
                  && tw_word[15:14] == strap_s
                  && tw_word[13]
                  && tw_word[12:8] == SEL_REG_ADDR;

   ////////////////////////////////////////////////////////////////////////////
   // i2c write slave
   vsw_i2c_state_type i_state_reg;
   logic [3:0]        i_cnt_reg;
   logic [7:0]        i_shift_reg;
   logic              i_ptr_reg;
   logic              i_rw_reg;
   logic              sda_oen_reg;
   logic              i_byte_end;
   logic              i_wr;

   assign i_byte_end = scl_fall && i_cnt_reg == I2C_BYTE_BITS;
   assign i_wr = (i_state_reg == I_DATA) && i_byte_end && !i_ptr_reg;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         i_cnt_reg   <= '0;
         i_shift_reg <= '0;
      end else if (!i2c_on || i2c_start || i_byte_end) begin
         i_cnt_reg   <= '0;
      end else if (scl_rise && (i_state_reg == I_ADDR || i_state_reg == I_REG
                                || i_state_reg == I_DATA)) begin
         i_cnt_reg   <= i_cnt_reg + 4'h1;
         i_shift_reg <= {i_shift_reg[6:0], sda_s};
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         i_state_reg <= I_IDLE;
         sda_oen_reg <= 1'b1;
         i_ptr_reg   <= 1'b0;
         i_rw_reg    <= 1'b0;
      end else if (!i2c_on || i2c_stop) begin
         i_state_reg <= I_IDLE;
         sda_oen_reg <= 1'b1;
         if (!pdn_s) begin
            i_ptr_reg <= 1'b0;
         end
      end else if (i2c_start) begin
         i_state_reg <= I_ADDR;
         sda_oen_reg <= 1'b1;
      end else begin
         case (i_state_reg)
            I_ADDR: begin
               if (i_byte_end) begin
                  if (i_shift_reg[7:1] == {I2C_FIXED_ADDR, strap_s}) begin
                     i_state_reg <= I_ACKA;
                     sda_oen_reg <= 1'b0;
                     i_rw_reg    <= i_shift_reg[0];
                  end else begin
                     i_state_reg <= I_IDLE;
                  end
               end
            end
            I_REG: begin
               if (i_byte_end) begin
                  i_ptr_reg   <= i_shift_reg[0];
                  i_state_reg <= I_ACKR;
                  sda_oen_reg <= 1'b0;
               end
            end
            I_DATA: begin
               if (i_byte_end) begin
                  i_ptr_reg   <= ~i_ptr_reg;
                  i_state_reg <= I_ACKD;
                  sda_oen_reg <= 1'b0;
               end
            end
            I_ACKA, I_ACKR, I_ACKD: begin
               if (scl_fall) begin
                  sda_oen_reg <= 1'b1;
                  if (i_state_reg == I_ACKA) begin
                     // reads are not served here: a read request is left idle
                     i_state_reg <= i_rw_reg ? I_IDLE : I_REG;
                  end else begin
                     i_state_reg <= I_DATA;
                  end
               end
            end
            default: begin
               i_state_reg <= I_IDLE;
            end
         endcase
      end
   end

   assign link.sda_dev_o   = 1'b0;
   assign link.sda_dev_oen = sda_oen_reg;

   ////////////////////////////////////////////////////////////////////////////
   // selector register and outputs
   logic [7:0] sel_reg;
   logic [7:0] sel_next;

   always_comb begin
      sel_next = sel_reg;
      if (tw_wr) begin
         sel_next = tw_word[7:0];
      end else if (i_wr) begin
         sel_next = i_shift_reg;
      end
      sel_next[7] = 1'b0;
      sel_next[3] = 1'b0;
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_reg <= SEL_REG_RESET;
      end else if (!pdn_s) begin
         sel_reg <= SEL_REG_RESET;
      end else begin
         sel_reg <= sel_next;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out1_source_select_o   <= SEL_OFF;
         out2_source_select_o   <= SEL_OFF;
         video_out_one_ground_o <= 1'b1;
         video_out_two_ground_o <= 1'b1;
         pump_internal_osc_o    <= 1'b0;
         sel_reg_o              <= SEL_REG_RESET;
      end else begin
         out1_source_select_o   <= sel_reg[OUT1_SEL_LSB +: 3];
         out2_source_select_o   <= sel_reg[OUT2_SEL_LSB +: 3];
         video_out_one_ground_o <= !pdn_s || sel_reg[OUT1_SEL_LSB +: 3] == SEL_OFF;
         video_out_two_ground_o <= !pdn_s || sel_reg[OUT2_SEL_LSB +: 3] == SEL_OFF;
         pump_internal_osc_o    <= !sync2_reg[SY_VID] && sync2_reg[SY_RAIL];
         sel_reg_o              <= sel_reg;
      end
   end

endmodule // vsw_dev_ctrl

// file: logic/vsw_host_ctrl.sv
// host end: avalon-mm slave that sends selector writes over 3-wire or i2c
`timescale 1ns/100ps
module vsw_host_ctrl
   import vsw_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        resetn_i,
   input  wire logic [1:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   vsw_link_if.host         link
);

   function automatic logic is_ack_bit(input logic [4:0] idx);
      is_ack_bit = idx == 5'h08 || idx == 5'h11 || idx == 5'h1a;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // avalon slave
   logic [3:0]         ctrl_reg;
   logic [12:0]        cmd_reg;
   logic               nack_reg;
   logic               wait_reg;
   vsw_host_state_type state_reg;
   logic               busy;
   logic               cmd_go;

   assign busy   = state_reg != H_IDLE;
   assign cmd_go = avs_write && !wait_reg && avs_address == HR_CMD;

   // a command write while busy is stalled, not dropped
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_reg     <= 1'b1;
         avs_readdata <= '0;
      end else if (wait_reg && (avs_read || avs_write)
                   && !(avs_write && avs_address == HR_CMD && busy)) begin
         wait_reg <= 1'b0;
         if (avs_address == HR_CTRL) begin
            avs_readdata <= {28'h0, ctrl_reg};
         end else if (avs_address == HR_CMD) begin
            avs_readdata <= {19'h0, cmd_reg};
         end else if (avs_address == HR_STATUS) begin
            avs_readdata <= {30'h0, nack_reg, busy};
         end else begin
            avs_readdata <= '0;
         end
      end else begin
         wait_reg <= 1'b1;
      end
   end
   assign avs_waitrequest = wait_reg;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_reg <= HR_CTRL_RESET;
         cmd_reg  <= '0;
      end else if (avs_write && !wait_reg && avs_address == HR_CTRL) begin
         ctrl_reg <= avs_writedata[3:0];
      end else if (cmd_go) begin
         cmd_reg <= avs_writedata[12:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link sequencer
   logic [4:0]  tick_cnt_reg;
   logic        tick;
   logic [1:0]  q_reg;
   logic [4:0]  idx_reg;
   logic [26:0] frame_reg;
   logic [1:0]  sda_sync_reg;
   logic        i2c_mode;
   logic [1:0]  tgt;
   logic [4:0]  last_idx;
   logic        csn_reg;
   logic        clk_reg;
   logic        dat_reg;
   logic        oen_reg;

   assign i2c_mode = ctrl_reg[CTRL_MODE_BIT];
   assign tgt      = ctrl_reg[CTRL_TGT_LSB +: 2];
   assign last_idx = i2c_mode ? I2C_LAST_INDEX : TW_LAST_INDEX;
   assign tick     = tick_cnt_reg == 5'(HOST_TICK_DIV - 1);

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_cnt_reg <= '0;
         sda_sync_reg <= 2'h3;
      end else begin
         tick_cnt_reg <= tick ? 5'h00 : tick_cnt_reg + 5'h01;
         sda_sync_reg <= {sda_sync_reg[0], link.sda};
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= H_IDLE;
         q_reg     <= '0;
         idx_reg   <= '0;
         frame_reg <= '0;
         nack_reg  <= 1'b0;
         csn_reg   <= 1'b1;
         clk_reg   <= 1'b1;
         dat_reg   <= 1'b0;
         oen_reg   <= 1'b1;
      end else if (cmd_go) begin
         state_reg <= H_START;
         q_reg     <= '0;
         idx_reg   <= '0;
         nack_reg  <= 1'b0;
         // 3-wire clock starts low so no edge lands as select falls
         clk_reg   <= i2c_mode;
         if (i2c_mode) begin
            // register address byte carries only the low address bit
            frame_reg <= {I2C_FIXED_ADDR, tgt, 1'b0, 1'b1, 7'h00,
                          avs_writedata[CMD_REG_LSB], 1'b1, avs_writedata[7:0], 1'b1};
         end else begin
            frame_reg <= {tgt, 1'b1, avs_writedata[CMD_REG_LSB +: 5],
                          avs_writedata[7:0], 11'h000};
         end
      end else if (tick) begin
         q_reg <= q_reg + 2'h1;
         case (state_reg)
            H_START: begin
               if (q_reg == 2'h0) begin
                  if (i2c_mode) begin
                     oen_reg <= 1'b0;
                  end else begin
                     csn_reg <= 1'b0;
                  end
               end else begin
                  clk_reg   <= 1'b0;
                  state_reg <= H_SHIFT;
                  q_reg     <= '0;
               end
            end
            H_SHIFT: begin
               if (q_reg == 2'h0) begin
                  dat_reg <= frame_reg[26];
                  oen_reg <= frame_reg[26];
               end else if (q_reg == 2'h1) begin
                  clk_reg <= 1'b1;
               end else if (q_reg == 2'h2) begin
                  if (i2c_mode && is_ack_bit(idx_reg) && sda_sync_reg[1]) begin
                     nack_reg <= 1'b1;
                  end
               end else begin
                  clk_reg   <= 1'b0;
                  frame_reg <= {frame_reg[25:0], 1'b1};
                  idx_reg   <= idx_reg + 5'h01;
                  if (idx_reg == last_idx) begin
                     state_reg <= H_STOP;
                     q_reg     <= '0;
                  end
               end
            end
            H_STOP: begin
               if (!i2c_mode) begin
                  csn_reg   <= 1'b1;
                  // idle levels, so a later switch to i2c shows no false start
                  clk_reg   <= 1'b1;
                  oen_reg   <= 1'b1;
                  state_reg <= H_IDLE;
               end else if (q_reg == 2'h0) begin
                  oen_reg <= 1'b0;
               end else if (q_reg == 2'h1) begin
                  clk_reg <= 1'b1;
               end else begin
                  oen_reg   <= 1'b1;
                  state_reg <= H_IDLE;
               end
            end
            default: begin
               q_reg <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         link.power_down_n    <= 1'b0;
         link.i2c_select      <= 1'b0;
         link.chip_select_n   <= 1'b1;
         link.serial_clock_in <= 1'b0;
         link.serial_data_in  <= 1'b0;
         link.scl             <= 1'b1;
         link.sda_host_o      <= 1'b0;
         link.sda_host_oen    <= 1'b1;
      end else begin
         link.power_down_n    <= ctrl_reg[CTRL_PDN_BIT];
         link.i2c_select      <= i2c_mode;
         link.chip_select_n   <= csn_reg | i2c_mode;
         link.serial_clock_in <= ~i2c_mode & clk_reg & ~csn_reg;
         link.serial_data_in  <= dat_reg;
         link.scl             <= ~i2c_mode | clk_reg;
         link.sda_host_o      <= 1'b0;
         link.sda_host_oen    <= ~i2c_mode | oen_reg;
      end
   end

endmodule // vsw_host_ctrl

// file: testbench/vsw_link_props.sv
// assertions on the link between host end and device end
`timescale 1ns/100ps
module vsw_link_props (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic i2c_select,
   input wire logic chip_select_n,
   input wire logic serial_clock_in,
   input wire logic serial_data_in,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_dev_oen
);
   ////////////////////////////////////////////////////////////////////////////
   logic [4:0] rise_cnt_reg;
   logic       sclk_prev_reg;

   // counts serial clock rises inside one select-low frame
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sclk_prev_reg <= 1'b0;
         rise_cnt_reg  <= 5'h00;
      end else begin
         sclk_prev_reg <= serial_clock_in;
         if (chip_select_n)
            rise_cnt_reg <= 5'h00;
         else if (serial_clock_in && !sclk_prev_reg)
            rise_cnt_reg <= rise_cnt_reg + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   sequence i2c_start_s;
      scl && $fell(sda);
   endsequence
   sequence sclk_rise_s;
      $rose(serial_clock_in) && !chip_select_n;
   endsequence

   // five cycles covers the device's three-cycle sync delay
   mode_sda_a: assert property ((!i2c_select)[*5] |-> sda_dev_oen)
      else $error("device drives sda in 3-wire mode");
   sclk_high_a: assert property ($rose(serial_clock_in) |-> serial_clock_in[*2])
      else $error("serial clock high too short");
   frame_len_a: assert property ($rose(chip_select_n) |-> rise_cnt_reg == 5'h10)
      else $error("frame closed without sixteen clocks");
   sdi_stable_a: assert property (serial_clock_in && $past(serial_clock_in)
      && !chip_select_n |-> $stable(serial_data_in))
      else $error("serial data changed while clock high");
   rw_bit_a: assert property (sclk_rise_s and rise_cnt_reg == 5'h02 |-> serial_data_in)
      else $error("frame direction bit not one");
   scl_low_a: assert property ($fell(scl) |-> (!scl)[*8])
      else $error("scl low phase too short");
   dev_sda_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oen))
      else $error("device moved sda while scl high");
   start_hold_a: assert property (i2c_start_s |-> scl[*4] ##[1:40] !scl)
      else $error("start condition not followed by clock");
endmodule // vsw_link_props

// file: testbench/tb_top.sv
// self-checking bench joining host end and device end
`timescale 1ns/100ps
`define CHK(g, e) \
   begin \
      check_count++; \
      if ((g) !== (e)) begin \
         fail_count++; \
         $display("[FAIL] %0t got %h exp %h", $time, g, e); \
      end \
   end
module tb_top;
   import vsw_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic [1:0]  avs_address = 2'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [31:0] rdata;
   logic [1:0]  strap = 2'h2;
   logic        video = 1'b1;
   logic        rail = 1'b0;
   logic [2:0]  sel1;
   logic [2:0]  sel2;
   logic        gnd1;
   logic        gnd2;
   logic        osc;
   logic [7:0]  sel_reg;
   int          fail_count = 0;
   int          check_count = 0;
   int          cyc = 0;

   ////////////////////////////////////////////////////////////////////////////
   vsw_link_if link ();
   vsw_host_ctrl u_vsw_host_ctrl (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .link(link));
   vsw_dev_ctrl u_vsw_dev_ctrl (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(link),
      .chip_addr_strap0_i(strap[0]), .chip_addr_strap1_i(strap[1]),
      .video_present_i(video), .rail_above_limit_i(rail),
      .out1_source_select_o(sel1), .out2_source_select_o(sel2),
      .video_out_one_ground_o(gnd1), .video_out_two_ground_o(gnd2),
      .pump_internal_osc_o(osc), .sel_reg_o(sel_reg));
   vsw_link_props u_vsw_link_props (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .i2c_select(link.i2c_select), .chip_select_n(link.chip_select_n),
      .serial_clock_in(link.serial_clock_in), .serial_data_in(link.serial_data_in),
      .scl(link.scl), .sda(link.sda), .sda_dev_oen(link.sda_dev_oen));

   always #20 clk_sys_i = ~clk_sys_i;

   // ceiling well above the dozen or so link transfers
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // one avalon cycle, held until waitrequest is seen low
   task automatic av_xfer(input logic wr, input logic [1:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk_sys_i); while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic cmd(input logic [4:0] r, input logic [7:0] d);
      av_xfer(1'b1, HR_CMD, {19'h0, r, d});
      do av_xfer(1'b0, HR_STATUS, 32'h0); while (rdata[0] !== 1'b0);
      repeat (4) @(posedge clk_sys_i);
   endtask

   task automatic ctrl(input logic [31:0] v);
      av_xfer(1'b1, HR_CTRL, v);
      repeat (6) @(posedge clk_sys_i);
   endtask

   task automatic chk_sel(input logic [7:0] e);
      `CHK(sel_reg, e)
      `CHK(sel1, e[2:0])
      `CHK(sel2, e[6:4])
      `CHK(gnd1, e[2:0] == 3'h0)
      `CHK(gnd2, e[6:4] == 3'h0)
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk_sel(8'h00);
      av_xfer(1'b0, 2'h3, 32'h0);
      `CHK(rdata, 32'h0)
      $display("test reset done");
   endtask

   // bits 7 and 3 are sent set to show they are dropped
   task automatic t_wire();
      ctrl(32'h9);
      av_xfer(1'b0, HR_CTRL, 32'h0);
      `CHK(rdata, 32'h9)
      for (int c = 0; c < 8; c++) begin
         cmd(5'h00, {1'b1, 3'(7 - c), 1'b1, 3'(c)});
         chk_sel({1'b0, 3'(7 - c), 1'b0, 3'(c)});
      end
      ctrl(32'h5);
      cmd(5'h00, 8'h11);
      chk_sel(8'h07);
      ctrl(32'h9);
      cmd(5'h01, 8'h22);
      chk_sel(8'h07);
      $display("test wire done");
   endtask

   task automatic t_pdn();
      ctrl(32'h8);
      chk_sel(8'h00);
      $display("test power down done");
   endtask

   task automatic t_i2c();
      ctrl(32'hb);
      cmd(5'h00, 8'h35);
      chk_sel(8'h35);
      `CHK(rdata[1], 1'b0)
      ctrl(32'h7);
      cmd(5'h00, 8'h46);
      chk_sel(8'h35);
      `CHK(rdata[1], 1'b1)
      strap <= 2'h1;
      repeat (6) @(posedge clk_sys_i);
      cmd(5'h00, 8'h62);
      chk_sel(8'h62);
      `CHK(rdata[1], 1'b0)
      $display("test i2c done");
   endtask

   task automatic t_osc();
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys_i);
         video <= k[1];
         rail <= k[0];
         repeat (6) @(posedge clk_sys_i);
         `CHK(osc, !k[1] && k[0])
      end
      $display("test pump clock done");
   endtask

   initial begin
      repeat (2) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      t_reset();
      t_wire();
      t_pdn();
      t_i2c();
      t_osc();
      end_of_test();
   end
endmodule // tb_top
